// File: rtl/hms_consts.svh
// Constants of the homing sequencer: method codes, lookup masks, status codes.
// Assumes it is included once per file by its bare name, after the package.
`ifndef HMS_CONSTS_SVH
`define HMS_CONSTS_SVH

// Method codes and ranges
`define HMS_M_NEG_LIM     8'h01
`define HMS_M_POS_LIM     8'h02
`define HMS_M_MOM_LO      8'h07
`define HMS_M_MOM_RT_HI   8'h0A
`define HMS_M_MOM_HI      8'h0E
`define HMS_M_NOIDX_LO    8'h11
`define HMS_M_NOIDX_HI    8'h1E
`define HMS_M_NOIDX_SHIFT 8'h10
`define HMS_M_IDX_NEG     8'h21
`define HMS_M_IDX_POS     8'h22
`define HMS_M_HERE        8'h23

// Per method 1..14: final approach is positive / target switch level is high
`define HMS_FINAL_POS_MASK 16'h2D32
`define HMS_LEVEL_MASK     16'h3350

// Status word bits 12 and 10
`define HMS_ST_BUSY     2'h0
`define HMS_ST_IDLE     2'h1
`define HMS_ST_ATTAINED 2'h2
`define HMS_ST_DONE     2'h3

`define HMS_POS_W 32

`endif

// File: rtl/hms_pkg.sv
// Types shared by the homing sequencer modules.
// Assumes nothing of its surroundings.
package hms_pkg;

    // Sequencer states
    typedef enum logic [2:0] {
        ST_IDLE, ST_SEEK, ST_INDEX, ST_HALT, ST_SETTLE, ST_DONE, ST_FAIL
    } hms_state_t;

    // Which switch is the homing signal
    typedef enum logic [1:0] {
        SIG_NEG, SIG_POS, SIG_HOME
    } hms_sig_t;

endpackage

// File: rtl/hms_edge.sv
// Registered level and edge pulses of one homing input.
// Assumes the input is already synchronous to sys_clk.
module hms_edge (
    input  wire logic sys_clk,
    input  wire logic sys_rst,
    input  wire logic sigIn,
    output logic      level,
    output logic      rise,
    output logic      fall
);
    logic prev_q;
    logic rise_q;
    logic fall_q;

    // Level and edges appear together one cycle late
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            prev_q <= 1'b0;
            rise_q <= 1'b0;
            fall_q <= 1'b0;
        end else begin
            prev_q <= sigIn;
            rise_q <= sigIn & ~prev_q;
            fall_q <= ~sigIn & prev_q;
        end
    end

    assign level = prev_q;
    assign rise  = rise_q;
    assign fall  = fall_q;
endmodule

// File: rtl/hms_method_dec.sv
// Decodes the homing method number into the sequencer's settings.
// Assumes the method is held steady while homing runs.
`include "hms_consts.svh"
module hms_method_dec (
    input  wire logic             sys_clk,
    input  wire logic             sys_rst,
    input  wire logic [7:0]       method,
    output logic                  methodOk,
    output logic                  useIndex,
    output logic                  momentary,
    output logic                  initPos,
    output logic                  finalPos,
    output logic                  targetLvl,
    output hms_pkg::hms_sig_t     sigSel,
    output logic                  indexOnly,
    output logic                  idxPos,
    output logic                  here
);
    localparam logic [15:0] FinalMask = `HMS_FINAL_POS_MASK;
    localparam logic [15:0] LevelMask = `HMS_LEVEL_MASK;
    logic       noIdx;
    logic [7:0] base;

    // Methods without index fold back onto their indexed twin
    always_comb begin
        noIdx = (method >= `HMS_M_NOIDX_LO) && (method <= `HMS_M_NOIDX_HI);
        base  = noIdx ? method - `HMS_M_NOIDX_SHIFT : method;
    end

    // Registered so the sequencer sees a clean decode
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            methodOk  <= 1'b0;
            useIndex  <= 1'b0;
            momentary <= 1'b0;
            initPos   <= 1'b0;
            finalPos  <= 1'b0;
            targetLvl <= 1'b0;
            sigSel    <= hms_pkg::SIG_HOME;
            indexOnly <= 1'b0;
            idxPos    <= 1'b0;
            here      <= 1'b0;
        end else begin
            // Reserved codes match no range
            methodOk  <= ((base >= `HMS_M_NEG_LIM) && (base <= `HMS_M_MOM_HI))
                         || (method == `HMS_M_IDX_NEG) || (method == `HMS_M_IDX_POS)
                         || (method == `HMS_M_HERE);
            useIndex  <= ~noIdx;
            momentary <= (base >= `HMS_M_MOM_LO) && (base <= `HMS_M_MOM_HI);
            initPos   <= base <= `HMS_M_MOM_RT_HI;
            finalPos  <= FinalMask[base[3:0]];
            targetLvl <= LevelMask[base[3:0]];
            sigSel    <= (base == `HMS_M_NEG_LIM) ? hms_pkg::SIG_NEG :
                         (base == `HMS_M_POS_LIM) ? hms_pkg::SIG_POS : hms_pkg::SIG_HOME;
            indexOnly <= (method == `HMS_M_IDX_NEG) || (method == `HMS_M_IDX_POS);
            idxPos    <= method == `HMS_M_IDX_POS;
            here      <= method == `HMS_M_HERE;
        end
    end
endmodule

// File: rtl/hms_homing_seq.sv
// Homing sequencer: seeks home from limit, home switch and index inputs.
// Assumes switch inputs synchronous to sys_clk and a motion loop that
// follows moveEn/moveDir and reports velZero.
`include "hms_consts.svh"
module hms_homing_seq (
    input  wire logic                   sys_clk,
    input  wire logic                   sys_rst,
    input  wire logic [7:0]             method,
    input  wire logic                   ctrlStart,
    input  wire logic                   ctrlHalt,
    input  wire logic [1:0]             haltOption,
    input  wire logic                   opEnabled,
    input  wire logic                   negLimit,
    input  wire logic                   posLimit,
    input  wire logic                   homeSwitch,
    input  wire logic                   indexPulse,
    input  wire logic                   velZero,
    input  wire logic [`HMS_POS_W-1:0]  posCount,
    input  wire logic [`HMS_POS_W-1:0]  homeOffset,
    output logic                        moveEn,
    output logic                        moveDir,
    output logic [1:0]                  stopMode,
    output logic                        homeLoad,
    output logic [`HMS_POS_W-1:0]       userOffset,
    output logic                        stsBit12,
    output logic                        stsBit10,
    output logic                        homingErr
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations

    hms_pkg::hms_state_t      state_q;
    hms_pkg::hms_sig_t        sigSel;
    logic                     methodOk;
    logic                     useIndex;
    logic                     momentary;
    logic                     initPos;
    logic                     finalPos;
    logic                     targetLvl;
    logic                     indexOnly;
    logic                     idxPos;
    logic                     here;
    logic                     negLvl;
    logic                     negRise;
    logic                     negFall;
    logic                     posLvl;
    logic                     posRise;
    logic                     posFall;
    logic                     homeLvl;
    logic                     homeRise;
    logic                     homeFall;
    logic                     idxRise;
    logic                     sigLvl;
    logic                     sigRise;
    logic                     sigFall;
    logic                     intoTarget;
    logic                     leaveTarget;
    logic                     limAhead;
    logic                     go;
    logic                     active;
    logic                     startPrev_q;
    logic                     dir_q;
    logic                     limRev_q;
    logic                     inIdx_q;
    logic                     moveEn_q;
    logic                     homeLoad_q;
    logic [1:0]               stopMode_q;
    logic [1:0]               sts_q;
    logic                     homingErr_q;
    logic [`HMS_POS_W-1:0]    userOffset_q;

    ////////////////////////////////////////////////////////////////////////
    // Input conditioning and method decode

    // Four homing signal sources
    hms_edge uNegEdge (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .sigIn   (negLimit),
        .level   (negLvl),
        .rise    (negRise),
        .fall    (negFall)
    );

    hms_edge uPosEdge (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .sigIn   (posLimit),
        .level   (posLvl),
        .rise    (posRise),
        .fall    (posFall)
    );

    hms_edge uHomeEdge (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .sigIn   (homeSwitch),
        .level   (homeLvl),
        .rise    (homeRise),
        .fall    (homeFall)
    );

    hms_edge uIdxEdge (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .sigIn   (indexPulse),
        .level   (),
        .rise    (idxRise),
        .fall    ()
    );

    hms_method_dec uDec (
        .sys_clk   (sys_clk),
        .sys_rst   (sys_rst),
        .method    (method),
        .methodOk  (methodOk),
        .useIndex  (useIndex),
        .momentary (momentary),
        .initPos   (initPos),
        .finalPos  (finalPos),
        .targetLvl (targetLvl),
        .sigSel    (sigSel),
        .indexOnly (indexOnly),
        .idxPos    (idxPos),
        .here      (here)
    );

    ////////////////////////////////////////////////////////////////////////
    // Event selection

    // Pick the method's switch; a limit that is the homing signal
    // must not count as an overtravel
    always_comb begin
        unique case (sigSel)
            hms_pkg::SIG_NEG: begin
                sigLvl  = negLvl;
                sigRise = negRise;
                sigFall = negFall;
            end
            hms_pkg::SIG_POS: begin
                sigLvl  = posLvl;
                sigRise = posRise;
                sigFall = posFall;
            end
            default: begin
                sigLvl  = homeLvl;
                sigRise = homeRise;
                sigFall = homeFall;
            end
        endcase
        intoTarget  = targetLvl ? sigRise : sigFall;
        leaveTarget = targetLvl ? sigFall : sigRise;
        // Positive direction is rightward, toward rising count
        limAhead    = dir_q ? (posLvl && sigSel != hms_pkg::SIG_POS)
                            : (negLvl && sigSel != hms_pkg::SIG_NEG);
    end

    // Start only on a fresh rise of the start bit with halt clear
    assign go     = ctrlStart & ~startPrev_q & ~ctrlHalt;
    assign active = (state_q == hms_pkg::ST_SEEK) || (state_q == hms_pkg::ST_INDEX);

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            startPrev_q <= 1'b0;
        end else begin
            startPrev_q <= ctrlStart;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer

    // Home captured here; offset shifts the user zero
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state_q      <= hms_pkg::ST_IDLE;
            dir_q        <= 1'b0;
            limRev_q     <= 1'b0;
            inIdx_q      <= 1'b0;
            moveEn_q     <= 1'b0;
            homeLoad_q   <= 1'b0;
            userOffset_q <= '0;
        end else begin
            homeLoad_q <= 1'b0;
            unique case (state_q)
                hms_pkg::ST_IDLE, hms_pkg::ST_DONE, hms_pkg::ST_FAIL: begin
                    moveEn_q <= 1'b0;
                    limRev_q <= 1'b0;
                    inIdx_q  <= 1'b0;
                    if (go && methodOk) begin
                        if (here) begin
                            // No enable needed to take the spot as home
                            userOffset_q <= homeOffset - posCount;
                            homeLoad_q   <= 1'b1;
                            state_q      <= hms_pkg::ST_SETTLE;
                        end else if (!opEnabled) begin
                            state_q <= hms_pkg::ST_IDLE;
                        end else if (indexOnly) begin
                            dir_q    <= idxPos;
                            inIdx_q  <= 1'b1;
                            moveEn_q <= 1'b1;
                            state_q  <= hms_pkg::ST_INDEX;
                        end else begin
                            // Momentary switch, not on it: fixed start
                            if (momentary && !sigLvl) begin
                                dir_q <= initPos;
                            end else begin
                                // Past the target side: go back first
                                dir_q <= (sigLvl == targetLvl) ? ~finalPos : finalPos;
                            end
                            moveEn_q <= 1'b1;
                            state_q  <= hms_pkg::ST_SEEK;
                        end
                    end
                end
                hms_pkg::ST_SEEK, hms_pkg::ST_INDEX: begin
                    if (!ctrlStart) begin
                        // Dropping start abandons the run
                        moveEn_q <= 1'b0;
                        state_q  <= hms_pkg::ST_IDLE;
                    end else if (ctrlHalt) begin
                        // Held, not lost: resumes when halt clears
                        moveEn_q <= 1'b0;
                        state_q  <= hms_pkg::ST_HALT;
                    end else if (state_q == hms_pkg::ST_INDEX && idxRise) begin
                        // First index past the edge is home
                        userOffset_q <= homeOffset - posCount;
                        homeLoad_q   <= 1'b1;
                        moveEn_q     <= 1'b0;
                        state_q      <= hms_pkg::ST_SETTLE;
                    end else if (state_q == hms_pkg::ST_SEEK && dir_q == finalPos
                                 && intoTarget) begin
                        if (useIndex) begin
                            inIdx_q <= 1'b1;
                            state_q <= hms_pkg::ST_INDEX;
                        end else begin
                            // Switch edge alone fixes home
                            userOffset_q <= homeOffset - posCount;
                            homeLoad_q   <= 1'b1;
                            moveEn_q     <= 1'b0;
                            state_q      <= hms_pkg::ST_SETTLE;
                        end
                    end else if (state_q == hms_pkg::ST_SEEK && dir_q != finalPos
                                 && leaveTarget) begin
                        // Reverse right after the change is seen
                        dir_q <= finalPos;
                    end else if (limAhead) begin
                        if (state_q == hms_pkg::ST_SEEK && momentary && !limRev_q) begin
                            // Ran away from the switch: turn at the limit
                            dir_q    <= ~dir_q;
                            limRev_q <= 1'b1;
                        end else begin
                            moveEn_q <= 1'b0;
                            state_q  <= hms_pkg::ST_FAIL;
                        end
                    end
                end
                hms_pkg::ST_HALT: begin
                    if (!ctrlStart) begin
                        state_q <= hms_pkg::ST_IDLE;
                    end else if (!ctrlHalt) begin
                        moveEn_q <= 1'b1;
                        state_q  <= inIdx_q ? hms_pkg::ST_INDEX : hms_pkg::ST_SEEK;
                    end
                end
                hms_pkg::ST_SETTLE: begin
                    // Home known; wait for the axis to stand still
                    if (velZero) begin
                        state_q <= hms_pkg::ST_DONE;
                    end
                end
            endcase
        end
    end

    // Halt option passed to the motion loop while stopped by halt
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            stopMode_q <= 2'h0;
        end else if (ctrlHalt) begin
            stopMode_q <= haltOption;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status word bits

    // Errors reuse progress codes, so the flag tells them apart
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            sts_q       <= `HMS_ST_IDLE;
            homingErr_q <= 1'b0;
        end else begin
            homingErr_q <= state_q == hms_pkg::ST_FAIL;
            unique case (state_q)
                hms_pkg::ST_SEEK, hms_pkg::ST_INDEX: sts_q <= `HMS_ST_BUSY;
                hms_pkg::ST_SETTLE: sts_q <= `HMS_ST_ATTAINED;
                hms_pkg::ST_DONE:   sts_q <= `HMS_ST_DONE;
                hms_pkg::ST_FAIL:   sts_q <= velZero ? `HMS_ST_IDLE : `HMS_ST_BUSY;
                default:            sts_q <= `HMS_ST_IDLE;
            endcase
        end
    end

    // Nothing else leaves the block
    assign moveEn     = moveEn_q;
    assign moveDir    = dir_q;
    assign stopMode   = stopMode_q;
    assign homeLoad   = homeLoad_q;
    assign userOffset = userOffset_q;
    assign stsBit12   = sts_q[1];
    assign stsBit10   = sts_q[0];
    assign homingErr  = homingErr_q;

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    reserved_ignore_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (state_q inside {hms_pkg::ST_IDLE, hms_pkg::ST_DONE, hms_pkg::ST_FAIL} && go
         && !methodOk) |=> ($stable(state_q) && !moveEn_q))
        else $error("reserved method started motion");

    here_capture_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (state_q inside {hms_pkg::ST_IDLE, hms_pkg::ST_DONE, hms_pkg::ST_FAIL} && go
         && methodOk && here) |=> (homeLoad_q && !moveEn_q)
            ##1 (!homeLoad_q && sts_q == `HMS_ST_ATTAINED))
        else $error("method 35 did not take present position");

    busy_status_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (state_q == hms_pkg::ST_SEEK) |=> (sts_q == `HMS_ST_BUSY && !homingErr_q))
        else $error("busy status wrong while seeking");

    error_status_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (state_q == hms_pkg::ST_FAIL && $stable(state_q)) |=>
            (homingErr_q && sts_q == ($past(velZero) ? `HMS_ST_IDLE : `HMS_ST_BUSY)))
        else $error("error status code wrong");

    start_drop_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (active && !ctrlStart) |=> (state_q == hms_pkg::ST_IDLE && !moveEn_q)
            ##1 (sts_q == `HMS_ST_IDLE))
        else $error("clearing start did not stop homing");

    halt_stop_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (active && ctrlStart && ctrlHalt) |=> (!moveEn_q && stopMode_q == $past(haltOption)))
        else $error("halt did not stop the axis");

    offset_apply_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        homeLoad_q |-> (userOffset_q == $past(homeOffset) - $past(posCount)))
        else $error("home offset not applied");

    index_home_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (state_q == hms_pkg::ST_INDEX && ctrlStart && !ctrlHalt && idxRise) |=>
            (homeLoad_q && state_q == hms_pkg::ST_SETTLE))
        else $error("index pulse not taken as home");

    reverse_dir_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (state_q == hms_pkg::ST_SEEK && ctrlStart && !ctrlHalt && dir_q != finalPos
         && leaveTarget) |=> (dir_q == $past(finalPos) && moveEn_q))
        else $error("no reversal after switch change");

    edge_home_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (state_q == hms_pkg::ST_SEEK && ctrlStart && !ctrlHalt && dir_q == finalPos
         && intoTarget && !useIndex) |=> homeLoad_q)
        else $error("switch edge not taken as home");

endmodule

// File: sim/hms_axis_model.sv
// Behavioural axis: integrates the move demand and derives the switches.
// Assumes the sequencer shares sys_clk; the bench loads start positions.
module hms_axis_model (
    input  wire logic        sys_clk,
    input  wire logic        loadEn,
    input  wire logic [31:0] loadVal,
    input  wire logic        moveEn,
    input  wire logic        moveDir,
    output logic [31:0]      posCount,
    output logic             negLimit,
    output logic             posLimit,
    output logic             homeSwitch,
    output logic             indexPulse,
    output logic             velZero
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0]  divQ = 2'h0;
    logic [31:0] nxt;
    ////////////////////////////////////////////////////////////
    // Slow axis, one count per 4 clocks, so capture latency costs no count
    assign nxt = moveDir ? posCount + 32'h1 : posCount - 32'h1;
    always @(posedge sys_clk) begin
        divQ <= divQ + 2'h1;
        velZero <= ~moveEn;
        indexPulse <= moveEn && divQ == 2'h3 && nxt[3:0] == 4'h0;
        if (loadEn)
            posCount <= loadVal;
        else if (moveEn && divQ == 2'h3)
            posCount <= nxt;
    end
    ////////////////////////////////////////////////////////////
    // Limit edges kept off index marks; home switch edges at 0x200 and 0x300 fall on them
    assign negLimit   = posCount < 32'h108;
    assign posLimit   = posCount > 32'h3F8;
    assign homeSwitch = posCount[31:8] == 24'h2;
endmodule

// File: sim/hms_homing_seq_tb.sv
// Self-checking bench of the homing sequencer against a slow axis model.
// Assumes the design files and the axis model are compiled first.
module hms_homing_seq_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk = 1'b0, sys_rst = 1'b1, loadEn = 1'b1;
    logic        ctrlStart = 1'b0, ctrlHalt = 1'b0, opEnabled = 1'b0;
    logic [7:0]  method = 8'h0, rnd = 8'h1C;
    logic [1:0]  haltOption = 2'h0, stopMode;
    logic [31:0] homeOffset = 32'h0, loadVal = 32'h185, posCount, userOffset;
    logic        negLimit, posLimit, homeSwitch, indexPulse, velZero;
    logic        moveEn, moveDir, homeLoad, stsBit12, stsBit10, homingErr;
    logic [31:0] expQ[$];
    logic [7:0]  resv[4] = '{8'h0F, 8'h10, 8'h1F, 8'h20};
    int          num_errors = 0, cmp_count = 0;

    always #5 sys_clk = ~sys_clk;
    hms_homing_seq hms_homing_seq_inst (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .method(method), .ctrlStart(ctrlStart),
        .ctrlHalt(ctrlHalt), .haltOption(haltOption), .opEnabled(opEnabled),
        .negLimit(negLimit), .posLimit(posLimit), .homeSwitch(homeSwitch),
        .indexPulse(indexPulse), .velZero(velZero), .posCount(posCount),
        .homeOffset(homeOffset), .moveEn(moveEn), .moveDir(moveDir), .stopMode(stopMode),
        .homeLoad(homeLoad), .userOffset(userOffset), .stsBit12(stsBit12),
        .stsBit10(stsBit10), .homingErr(homingErr));
    hms_axis_model hms_axis_model_inst (
        .sys_clk(sys_clk), .loadEn(loadEn), .loadVal(loadVal), .moveEn(moveEn),
        .moveDir(moveDir), .posCount(posCount), .negLimit(negLimit), .posLimit(posLimit),
        .homeSwitch(homeSwitch), .indexPulse(indexPulse), .velZero(velZero));
    ////////////////////////////////////////////////////////////
    // Verdict, comparison and pseudo-random helpers
    task automatic end_of_test();
        $display("compares %0d errors %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chkWord(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    // Bounded wait for a status code; running out ends the run
    task automatic waitSts(input logic [1:0] e, input int n);
        int i;
        @(negedge sys_clk);
        for (i = 0; i < n && {stsBit12, stsBit10} !== e; i++)
            @(negedge sys_clk);
        chkWord({stsBit12, stsBit10}, e);
        if ({stsBit12, stsBit10} !== e)
            end_of_test();
    endtask
    ////////////////////////////////////////////////////////////
    // One homing run: mode 0 plain, 1 halted midway, 2 start dropped, 3 fails at limit
    task automatic runHome(input logic [7:0] m, input logic [31:0] p,
                           input logic en, input logic [31:0] h, input logic [1:0] mode);
        rnd = lfsr(rnd);
        @(posedge sys_clk);
        method <= m;
        opEnabled <= en;
        loadEn <= 1'b1;
        loadVal <= p;
        homeOffset <= {rnd, 24'h5A};
        @(posedge sys_clk);
        loadEn <= 1'b0;
        if (!mode[1])
            expQ.push_back({rnd, 24'h5A} - h);
        repeat (2) @(posedge sys_clk);
        ctrlStart <= 1'b1;
        if (m != 8'h23)
            waitSts(2'h0, 8);
        @(posedge sys_clk);
        if (mode == 2'h1) begin
            ctrlHalt <= 1'b1;
            haltOption <= rnd[1:0];
            repeat (3) @(negedge sys_clk);
            chkWord({stopMode, moveDir, moveEn, stsBit12, stsBit10},
                    {rnd[1:0], m == 8'h22, 3'h1});
            @(posedge sys_clk);
            ctrlHalt <= 1'b0;
        end
        if (mode == 2'h2) begin
            ctrlStart <= 1'b0;
            waitSts(2'h1, 4);
        end else begin
            waitSts((mode == 2'h3) ? 2'h1 : 2'h3, 3000);
            chkWord({homingErr, moveEn}, {mode == 2'h3, 1'b0});
            @(posedge sys_clk);
            ctrlStart <= 1'b0;
        end
    endtask
    ////////////////////////////////////////////////////////////
    // Watcher: each home capture must match the oldest note
    initial forever begin
        @(negedge sys_clk);
        if (homeLoad === 1'b1) begin
            @(negedge sys_clk);
            chkWord(userOffset, expQ.size() ? expQ.pop_front() : 32'hX);
        end
    end
    // Main sequence
    initial begin
        repeat (16) @(posedge sys_clk);
        sys_rst <= 1'b0;
        runHome(8'h21, 32'h185, 1'b1, 32'h180, 2'h0);
        runHome(8'h22, 32'h185, 1'b1, 32'h190, 2'h1);
        runHome(8'h21, 32'h185, 1'b1, 32'h0, 2'h2);
        runHome(8'h01, 32'h180, 1'b1, 32'h110, 2'h0);
        runHome(8'h02, 32'h380, 1'b1, 32'h3F0, 2'h0);
        runHome(8'h11, 32'h180, 1'b1, 32'h108, 2'h0);
        runHome(8'h04, 32'h380, 1'b1, 32'h0, 2'h3);
        runHome(8'h23, 32'h1234567, 1'b0, 32'h1234567, 2'h0);
        // Reserved codes leave the axis still and the done status as it was
        for (int i = 0; i < 4; i++) begin
            @(posedge sys_clk);
            method <= resv[i];
            opEnabled <= 1'b1;
            repeat (3) @(posedge sys_clk);
            ctrlStart <= 1'b1;
            repeat (20) @(negedge sys_clk);
            chkWord({moveEn, stsBit12, stsBit10}, 32'h3);
            @(posedge sys_clk);
            ctrlStart <= 1'b0;
        end
        repeat (4) @(posedge sys_clk);
        end_of_test();
    end
endmodule
